// ---- hdl/llf_pkg.sv ----
// Constants, input positions and lookup table for the light-load controller
package llf_pkg;
  // Clock rate and documented times
  localparam int CLK_MHZ = 100;
  localparam int MAX_PERIOD_US = 40;
  localparam int VALLEY_TOUT_US = 6;
  localparam int DEAD_MAX_US = 36;
  localparam int LOCKOUT_US = 1000;
  localparam int QUIET_US = 1250;
  localparam int MAX_PERIOD_CYC = MAX_PERIOD_US * CLK_MHZ;
  localparam int VALLEY_TOUT_CYC = VALLEY_TOUT_US * CLK_MHZ;
  localparam int DEAD_MAX_CYC = DEAD_MAX_US * CLK_MHZ;
  localparam int LOCKOUT_CYC = LOCKOUT_US * CLK_MHZ;
  localparam int QUIET_CYC = QUIET_US * CLK_MHZ;

  // Counter widths
  localparam int PER_W = 12;
  localparam int TMR_W = 20;

  // Valley and burst figures
  localparam logic [2:0] VALLEY_FOLD = 3'h6;
  localparam logic [2:0] VALLEY_SAT = 3'h7;
  localparam logic [1:0] BURST_PULSES = 2'h3;

  // Peak floor codes, 10 mV per step
  localparam logic [7:0] PEAK_BASE = 8'h28;
  localparam logic [7:0] PEAK_STEP = 8'h28;
  localparam logic [15:0] DEPTH_FULL = 16'h00ff;

  // Sense bins and minimum current-sense setpoint in mV
  localparam logic [4:0] BIN_MAX = 5'h11;
  localparam logic [7:0] CS_MIN_RESET = 8'hc8;
  localparam logic [7:0] CS_MIN_TABLE [0:17] = '{
    8'h50, 8'h5a, 8'h64, 8'h6e, 8'h78, 8'h7d, 8'h87, 8'h8c, 8'h96,
    8'h9b, 8'ha0, 8'ha5, 8'haf, 8'hb4, 8'hb9, 8'hbe, 8'hc3, 8'hc8};

  // Positions in the comparator vector
  localparam int SY_N = 10;
  localparam int SY_FOLD_IN = 0;
  localparam int SY_FOLD_OUT = 1;
  localparam int SY_V5 = 2;
  localparam int SY_SKIP = 3;
  localparam int SY_SEXIT = 4;
  localparam int SY_BEXIT = 5;
  localparam int SY_VALLEY = 6;
  localparam int SY_DEMAG = 7;
  localparam int SY_SECZ = 8;
  localparam int SY_CS = 9;

  typedef enum logic [1:0] {
    SK_RUN = 2'b00,
    SK_STOP = 2'b01,
    SK_BURST = 2'b10
  } llf_skip_t;

  typedef enum logic [1:0] {
    DR_OFF = 2'b00,
    DR_DEAD = 2'b01,
    DR_ON = 2'b10
  } llf_drive_t;
endpackage

// ---- hdl/llf_tmr_if.sv ----
// Start and status pair between the controller and a one-shot timer
`timescale 1ns/1ps
interface llf_tmr_if;
  logic start;
  logic running;
  modport ctl (output start, input running);
  modport tmr (input start, output running);
endinterface

// ---- hdl/llf_sync.sv ----
// Two-flop synchroniser for a vector of comparator levels
`timescale 1ns/1ps
module llf_sync #(
  parameter int N = 1
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Levels
  input wire logic [N-1:0] i_async,
  output logic [N-1:0] o_sync
);
  generate
    if (N < 1) begin : g_bad
      $error("llf_sync needs N of at least 1");
    end
    for (genvar k = 0; k < N; k++) begin : g_bit
      logic meta;
      logic held;
      always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
          meta <= 1'b0;
          held <= 1'b0;
        end else if (i_ce) begin
          meta <= i_async[k];
          held <= meta;
        end
      end
      assign o_sync[k] = held;
    end
  endgenerate
endmodule

// ---- hdl/llf_timer.sv ----
// Retriggerable one-shot timer; runs CYCLES enabled clocks after start
`timescale 1ns/1ps
module llf_timer import llf_pkg::*; #(
  parameter int CYCLES = 1
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Control
  llf_tmr_if.tmr tif
);
  logic [TMR_W-1:0] cnt;
  logic [TMR_W-1:0] next_cnt;

  generate
    if (CYCLES < 1 || CYCLES >= (1 << TMR_W)) begin : g_bad
      $error("llf_timer CYCLES out of range");
    end
  endgenerate

  always_comb begin
    next_cnt = cnt;
    if (tif.start) begin
      next_cnt = TMR_W'(CYCLES);
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= '0;
    end else if (i_ce) begin
      cnt <= next_cnt;
    end
  end

  assign tif.running = (cnt != '0);
endmodule

// ---- hdl/llf_light_load_ctrl.sv ----
// Light-load foldback, minimum-frequency clamp, quiet-skip and skip auto-tune
`timescale 1ns/1ps
module llf_light_load_ctrl import llf_pkg::*; #(
  parameter int LOCKOUT_CYCLES = LOCKOUT_CYC,
  parameter int QUIET_CYCLES = QUIET_CYC
) (
  // Clock, reset, enable
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Feedback comparators
  input wire logic i_fb_fold_entry,
  input wire logic i_fb_fold_exit,
  input wire logic i_fb_valley5,
  input wire logic i_fb_skip,
  input wire logic i_fb_skip_exit,
  input wire logic i_fb_burst_exit,
  // Quantised feedback and valley choice
  input wire logic [7:0] i_fold_depth,
  input wire logic [2:0] i_valley_sel,
  // Demagnetization sense and current sense
  input wire logic i_demag_sense_in,
  input wire logic i_demag_done,
  input wire logic i_sec_zero,
  input wire logic [4:0] i_vsense_bin,
  input wire logic i_cs_trip,
  // Outputs
  output logic o_gate_drive_out,
  output logic o_foldback_mode,
  output logic o_burst_mode,
  output logic [7:0] o_peak_floor,
  output logic [7:0] o_cs_min,
  output logic [2:0] o_valley_count
);
  localparam int TOUT_LAST = VALLEY_TOUT_CYC - 1;
  localparam int PER_LAST = MAX_PERIOD_CYC - 1;

  generate
    if (LOCKOUT_CYCLES < 1 || QUIET_CYCLES < 1) begin : g_bad
      $error("llf_light_load_ctrl timer lengths must be positive");
    end
  endgenerate

  logic [SY_N-1:0] sy;
  logic [SY_N-1:0] raw;
  llf_tmr_if lk ();
  llf_tmr_if qt ();

  // Comparators pass two flops before any logic looks at them
  assign raw = {i_cs_trip, i_sec_zero, i_demag_done, i_demag_sense_in, i_fb_burst_exit,
                i_fb_skip_exit, i_fb_skip, i_fb_valley5, i_fb_fold_exit, i_fb_fold_entry};

  llf_sync #(.N(SY_N)) u_sync (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_async(raw),
    .o_sync(sy)
  );

  llf_timer #(.CYCLES(LOCKOUT_CYCLES)) u_lock (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .tif(lk.tmr)
  );

  llf_timer #(.CYCLES(QUIET_CYCLES)) u_quiet (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .tif(qt.tmr)
  );

  // State
  logic fold, next_fold;
  llf_skip_t sk, next_sk;
  llf_drive_t dst, next_dst;
  logic pend, next_pend;
  logic [1:0] cnt, next_cnt;
  logic [2:0] vcnt, next_vcnt;
  logic [PER_W-1:0] tout, next_tout;
  logic [PER_W-1:0] per, next_per;
  logic [PER_W-1:0] dtc, next_dtc;
  logic val_d, next_val_d;
  logic secz_d, next_secz_d;
  logic [4:0] bin, next_bin;
  logic drive, next_drive;
  logic [7:0] peak, next_peak;
  logic [7:0] csmin, next_csmin;
  logic lock_start, quiet_start;

  // Derived terms
  logic [19:0] dt_prod;
  logic [PER_W-1:0] dt_target;
  logic [15:0] red_prod;
  logic val_ev, tout_hit, val_step, val_hit, clamp_hit, allow, pulse_end;

  assign lk.start = lock_start;
  assign qt.start = quiet_start;

  always_comb begin
    dt_prod = 20'(i_fold_depth) * 20'(DEAD_MAX_CYC);
    dt_target = PER_W'(dt_prod / 20'(DEPTH_FULL));
    red_prod = 16'(i_fold_depth) * 16'(PEAK_STEP);
    val_ev = sy[SY_VALLEY] && !val_d;
    tout_hit = (tout == PER_W'(TOUT_LAST));
    val_step = (dst == DR_OFF) && (val_ev || tout_hit);
    // One bit wider so a saturated count still reaches the chosen valley
    val_hit = val_step && (({1'b0, vcnt} + 4'h1) >= {1'b0, i_valley_sel});
    clamp_hit = (per == PER_W'(PER_LAST)) && sy[SY_DEMAG];
    pulse_end = (dst == DR_ON) && sy[SY_CS];
    allow = ((sk == SK_RUN) && !sy[SY_SKIP]) ||
            ((sk == SK_BURST) && !(pend && cnt == BURST_PULSES));
  end

  // Foldback entry and exit
  always_comb begin
    next_fold = fold;
    lock_start = 1'b0;
    if (fold && (sy[SY_SKIP] || sy[SY_V5])) begin
      next_fold = 1'b0;
      lock_start = 1'b1;
    end else if (!lk.running) begin
      if (!fold && i_valley_sel == VALLEY_FOLD && sy[SY_FOLD_IN]) begin
        next_fold = 1'b1;
        lock_start = 1'b1;
      end else if (fold && sy[SY_FOLD_OUT]) begin
        next_fold = 1'b0;
        lock_start = 1'b1;
      end
    end
    // Floor raised on entry, then lowered as feedback falls
    next_peak = fold ? 8'(PEAK_BASE + PEAK_STEP - red_prod[15:8]) : PEAK_BASE;
  end

  // Skip and quiet-skip burst control
  always_comb begin
    next_sk = sk;
    next_pend = pend;
    next_cnt = cnt;
    quiet_start = 1'b0;
    case (sk)
      SK_RUN: begin
        if (sy[SY_SKIP] && dst != DR_ON) begin
          next_sk = SK_STOP;
        end
      end
      SK_STOP: begin
        if (sy[SY_BEXIT]) begin
          next_sk = SK_RUN;
        end else if (sy[SY_SEXIT] && !qt.running) begin
          next_sk = SK_BURST;
          quiet_start = 1'b1;
          next_cnt = 2'h0;
          next_pend = 1'b0;
        end
      end
      SK_BURST: begin
        if (pulse_end && cnt != BURST_PULSES) begin
          next_cnt = cnt + 2'h1;
        end
        if (sy[SY_SKIP]) begin
          next_pend = 1'b1;
        end
        if (sy[SY_BEXIT]) begin
          next_sk = SK_RUN;
        end else if (pend && cnt == BURST_PULSES && dst != DR_ON) begin
          next_sk = SK_STOP;
        end
      end
      default: begin
        next_sk = SK_RUN;
      end
    endcase
  end

  // Gate drive sequencing; frequency follows dead-time in foldback
  always_comb begin
    next_dst = dst;
    case (dst)
      DR_OFF: begin
        if (allow && clamp_hit) begin
          next_dst = DR_ON;
        end else if (allow && val_hit) begin
          next_dst = (fold && dt_target != '0) ? DR_DEAD : DR_ON;
        end
      end
      DR_DEAD: begin
        if (!allow || !fold) begin
          next_dst = DR_OFF;
        end else if (clamp_hit || (dtc + PER_W'(1)) >= dt_target) begin
          next_dst = DR_ON;
        end
      end
      DR_ON: begin
        if (sy[SY_CS]) begin
          next_dst = DR_OFF;
        end
      end
      default: begin
        next_dst = DR_OFF;
      end
    endcase
    next_drive = (next_dst == DR_ON);
    next_dtc = (dst == DR_DEAD) ? dtc + PER_W'(1) : '0;
    next_val_d = sy[SY_VALLEY];
    if (dst == DR_ON) begin
      next_vcnt = 3'h0;
    end else if (val_step && vcnt != VALLEY_SAT) begin
      next_vcnt = vcnt + 3'h1;
    end else begin
      next_vcnt = vcnt;
    end
    next_tout = (dst != DR_OFF || val_ev || tout_hit) ? '0 : tout + PER_W'(1);
    if (next_dst == DR_ON && dst != DR_ON) begin
      next_per = '0;
    end else if (per != PER_W'(PER_LAST)) begin
      next_per = per + PER_W'(1);
    end else begin
      next_per = per;
    end
  end

  // Output-voltage sample for skip auto-tuning
  always_comb begin
    next_secz_d = sy[SY_SECZ];
    next_bin = bin;
    if (sy[SY_SECZ] && !secz_d) begin
      next_bin = (i_vsense_bin > BIN_MAX) ? BIN_MAX : i_vsense_bin;
    end
    next_csmin = CS_MIN_TABLE[bin];
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      fold <= 1'b0;
      sk <= SK_RUN;
      dst <= DR_OFF;
      pend <= 1'b0;
      cnt <= 2'h0;
      vcnt <= 3'h0;
      tout <= '0;
      per <= '0;
      dtc <= '0;
      val_d <= 1'b0;
      secz_d <= 1'b0;
      bin <= BIN_MAX;
      drive <= 1'b0;
      peak <= PEAK_BASE;
      csmin <= CS_MIN_RESET;
    end else if (i_ce) begin
      fold <= next_fold;
      sk <= next_sk;
      dst <= next_dst;
      pend <= next_pend;
      cnt <= next_cnt;
      vcnt <= next_vcnt;
      tout <= next_tout;
      per <= next_per;
      dtc <= next_dtc;
      val_d <= next_val_d;
      secz_d <= next_secz_d;
      bin <= next_bin;
      drive <= next_drive;
      peak <= next_peak;
      csmin <= next_csmin;
    end
  end

  assign o_gate_drive_out = drive;
  assign o_foldback_mode = fold;
  assign o_burst_mode = (sk != SK_RUN);
  assign o_peak_floor = peak;
  assign o_cs_min = csmin;
  assign o_valley_count = vcnt;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);

  property p_fold_entry;
    i_ce && !fold && !lk.running && i_valley_sel == VALLEY_FOLD && sy[SY_FOLD_IN] |=> fold;
  endproperty
  a_fold_entry: assert property (p_fold_entry) else $error("foldback entry missed");

  property p_lock_start;
    i_ce && next_fold != fold |=> lk.running;
  endproperty
  a_lock_start: assert property (p_lock_start) else $error("lockout not started");

  property p_lock_hold;
    i_ce && lk.running && fold && !sy[SY_SKIP] && !sy[SY_V5] |=> fold;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("foldback left in lockout");

  property p_forced_exit;
    i_ce && fold && (sy[SY_SKIP] || sy[SY_V5]) |=> !fold;
  endproperty
  a_forced_exit: assert property (p_forced_exit) else $error("forced exit missed");

  property p_no_dead;
    i_ce && dst == DR_OFF && !fold |=> dst != DR_DEAD;
  endproperty
  a_no_dead: assert property (p_no_dead) else $error("dead-time outside foldback");

  property p_clamp;
    i_ce && dst == DR_OFF && per == PER_W'(PER_LAST) && sy[SY_DEMAG] && allow |=> drive;
  endproperty
  a_clamp: assert property (p_clamp) else $error("minimum frequency not forced");

  property p_clamp_demag;
    i_ce && dst == DR_OFF && !sy[SY_DEMAG] && !val_hit |=> !drive;
  endproperty
  a_clamp_demag: assert property (p_clamp_demag) else $error("pulse before demag");

  property p_no_trunc;
    i_ce && drive && !sy[SY_CS] |=> drive;
  endproperty
  a_no_trunc: assert property (p_no_trunc) else $error("pulse truncated");

  property p_skip_hold;
    i_ce && sk == SK_RUN && sy[SY_SKIP] && !drive |=> !drive;
  endproperty
  a_skip_hold: assert property (p_skip_hold) else $error("pulse during skip");

  property p_quiet;
    i_ce && sk == SK_STOP && qt.running && !sy[SY_BEXIT] |=> sk == SK_STOP ##0 !drive;
  endproperty
  a_quiet: assert property (p_quiet) else $error("burst before quiet expiry");

  property p_three;
    i_ce && sk == SK_BURST && cnt != BURST_PULSES |=> sk != SK_STOP;
  endproperty
  a_three: assert property (p_three) else $error("burst under three pulses");

  property p_burst_exit;
    i_ce && sk != SK_RUN && sy[SY_BEXIT] |=> sk == SK_RUN;
  endproperty
  a_burst_exit: assert property (p_burst_exit) else $error("burst exit missed");

  c_fold: cover property (i_ce && !fold ##1 fold);
  c_burst: cover property (sk == SK_BURST && cnt == BURST_PULSES ##[1:50] sk == SK_STOP);
  c_dead: cover property (dst == DR_DEAD && next_dst == DR_ON ##1 drive);
endmodule

// ---- test/llf_stage_model.sv ----
// Behavioural flyback stage: on-time, demagnetization and valley ringing
`timescale 1ns/1ps
module llf_stage_model (
  // Clock
  input wire logic i_clock,
  // Gate and on-time length
  input wire logic i_gate,
  input wire logic [7:0] i_on_cyc,
  // High damps the ringing so no valley shows
  input wire logic i_damped,
  // Sense outputs
  output logic o_cs_trip,
  output logic o_demag_done,
  output logic o_sec_zero,
  output logic o_demag_sense
);
  localparam int DEMAG = 8;
  localparam int RING = 6;
  int t = 0;
  logic gate_q = 1'b0;

  // Time since the last gate edge, saturating
  always @(posedge i_clock) begin
    gate_q <= i_gate;
    t <= (i_gate !== gate_q) ? 0 : ((t < 10000) ? t + 1 : t);
  end

  // Switch follows the gate one clock late, in step with the time count
  assign o_cs_trip = gate_q && (t >= int'(i_on_cyc));
  assign o_sec_zero = !gate_q && (t == DEMAG || t == DEMAG + 1);
  assign o_demag_done = !gate_q && (t >= DEMAG);
  // Ringing runs while off, until the time count saturates at 10000, unless damped
  assign o_demag_sense = !gate_q && !i_damped && (t > DEMAG) && (t % RING < 2);
endmodule

// ---- test/light_load_foldback_skip_ctrl_bench.sv ----
// Self-checking bench for the light-load controller
`timescale 1ns/1ps
module light_load_foldback_skip_ctrl_bench;
  import llf_pkg::*;
  // Short lockout and quiet counts keep the run brief
  localparam int LOCK = 50;
  localparam int QUIET = 400;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic fb_entry = 1'b0, fb_exit = 1'b0, fb_v5 = 1'b0, fb_skip = 1'b0;
  logic fb_sexit = 1'b0, fb_bexit = 1'b0;
  logic ce = 1'b1, damped = 1'b0;
  logic [7:0] depth = 8'h00, on_cyc = 8'h10;
  logic [2:0] vsel = 3'h1;
  logic [4:0] bin = 5'h00;
  logic cs_trip, demag_done, sec_zero, demag_sense, gate, fold, burst;
  logic [7:0] floor_code, cs_min;
  logic [2:0] vcount;
  int mismatches = 0, checks = 0, seed = 71, cycles = 0, np, n2, gap;

  llf_light_load_ctrl #(.LOCKOUT_CYCLES(LOCK), .QUIET_CYCLES(QUIET)) dut (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_ce(ce),
    .i_fb_fold_entry(fb_entry), .i_fb_fold_exit(fb_exit), .i_fb_valley5(fb_v5),
    .i_fb_skip(fb_skip), .i_fb_skip_exit(fb_sexit), .i_fb_burst_exit(fb_bexit),
    .i_fold_depth(depth), .i_valley_sel(vsel), .i_demag_sense_in(demag_sense),
    .i_demag_done(demag_done), .i_sec_zero(sec_zero), .i_vsense_bin(bin),
    .i_cs_trip(cs_trip), .o_gate_drive_out(gate), .o_foldback_mode(fold),
    .o_burst_mode(burst), .o_peak_floor(floor_code), .o_cs_min(cs_min),
    .o_valley_count(vcount));

  llf_stage_model stage (.i_clock(i_clock), .i_gate(gate), .i_on_cyc(on_cyc),
    .i_damped(damped),
    .o_cs_trip(cs_trip), .o_demag_done(demag_done), .o_sec_zero(sec_zero),
    .o_demag_sense(demag_sense));

  initial begin
    forever #5 i_clock = ~i_clock;
  end

  function automatic logic [7:0] cs_exp(input logic [4:0] b);
    logic [7:0] tbl [0:17];
    tbl = '{8'h50, 8'h5a, 8'h64, 8'h6e, 8'h78, 8'h7d, 8'h87, 8'h8c, 8'h96,
      8'h9b, 8'ha0, 8'ha5, 8'haf, 8'hb4, 8'hb9, 8'hbe, 8'hc3, 8'hc8};
    return (b > 5'h11) ? tbl[17] : tbl[b];
  endfunction

  function automatic logic [7:0] floor_exp(input logic [7:0] d);
    return 8'h50 - 8'((16'(d) * 16'h0028) >> 8);
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Counts gate rising edges over a window
  task automatic pulses(input int n, output int cnt);
    logic prev;
    cnt = 0;
    prev = gate;
    repeat (n) begin
      step(1);
      if (gate === 1'b1 && prev !== 1'b1) cnt++;
      prev = gate;
    end
  endtask

  // Cycles until the next gate rising edge, capped at lim
  task automatic wait_rise(input int lim, output int n);
    logic prev;
    logic seen;
    n = 0;
    seen = 1'b0;
    prev = gate;
    while (!seen && n < lim) begin
      step(1);
      n++;
      seen = (gate === 1'b1 && prev !== 1'b1);
      prev = gate;
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      $display("BAD timeout expected end seen hang");
      end_sim();
    end
  end

  initial begin
    step(6);
    check("floor reset", 8'h28, floor_code);
    check("cs_min reset", 8'hc8, cs_min);
    i_nrst = 1'b1;
    on_cyc = 8'h0a + 8'({$random(seed)} % 11);
    for (int i = 0; i < 22; i++) begin
      bin = (i < 18) ? 5'(i) : 5'($random(seed));
      for (int n = 0; n < 500 && sec_zero !== 1'b1; n++) step(1);
      step(6);
      check("cs_min", cs_exp(bin), cs_min);
    end
    $display("test auto-tune done");
    vsel = 3'h6;
    depth = 8'($random(seed));
    fb_entry = 1'b1;
    step(5);
    check("fold entry", 8'h01, 8'(fold));
    check("floor", floor_exp(depth), floor_code);
    fb_entry = 1'b0;
    fb_exit = 1'b1;
    step(10);
    check("fold held", 8'h01, 8'(fold));
    step(LOCK);
    check("fold exit", 8'h00, 8'(fold));
    check("floor base", 8'h28, floor_code);
    fb_exit = 1'b0;
    fb_entry = 1'b1;
    step(10);
    check("fold blocked", 8'h00, 8'(fold));
    step(LOCK);
    check("fold again", 8'h01, 8'(fold));
    fb_v5 = 1'b1;
    step(5);
    check("fold forced", 8'h00, 8'(fold));
    $display("test foldback done");
    fb_v5 = 1'b0;
    fb_entry = 1'b0;
    vsel = 3'h1;
    fb_skip = 1'b1;
    for (int n = 0; n < 300 && burst !== 1'b1; n++) step(1);
    check("burst", 8'h01, 8'(burst));
    pulses(200, np);
    check("skip pulses", 8'h00, 8'(np));
    fb_skip = 1'b0;
    fb_sexit = 1'b1;
    pulses(4, np);
    fb_sexit = 1'b0;
    fb_skip = 1'b1;
    // Window runs past quiet expiry with no skip exit
    pulses(600, n2);
    check("burst pulses", 8'h03, 8'(np + n2));
    check("burst held", 8'h01, 8'(burst));
    fb_skip = 1'b0;
    fb_sexit = 1'b1;
    pulses(4, np);
    fb_sexit = 1'b0;
    fb_skip = 1'b1;
    pulses(250, n2);
    fb_skip = 1'b0;
    fb_sexit = 1'b1;
    pulses(100, n2);
    check("quiet hold", 8'h00, 8'(n2));
    pulses(300, n2);
    check("quiet resume", 8'h01, 8'(n2 > 0));
    fb_sexit = 1'b0;
    fb_skip = 1'b1;
    pulses(120, np);
    fb_skip = 1'b0;
    fb_bexit = 1'b1;
    // Exit lands while the quiet timer still runs
    pulses(20, n2);
    check("burst exit", 8'h00, 8'(burst));
    check("exit resume", 8'h01, 8'(n2 > 0));
    $display("test quiet-skip done");
    fb_bexit = 1'b0;
    damped = 1'b1;
    wait_rise(2000, gap);
    while (gate === 1'b1) step(1);
    wait_rise(2000, gap);
    check("timeout gap", 16'(VALLEY_TOUT_CYC), 16'(gap));
    while (gate === 1'b1) step(1);
    ce = 1'b0;
    pulses(700, np);
    check("frozen pulses", 8'h00, 8'(np));
    ce = 1'b1;
    wait_rise(2000, gap);
    check("gap after freeze", 16'(VALLEY_TOUT_CYC), 16'(gap));
    $display("test valley timeout done");
    vsel = 3'h6;
    depth = 8'hff;
    fb_entry = 1'b1;
    wait_rise(5000, gap);
    wait_rise(5000, gap);
    check("clamp period", 16'(MAX_PERIOD_CYC), 16'(gap));
    check("fold deep", 8'h01, 8'(fold));
    $display("test minimum frequency done");
    end_sim();
  end
endmodule
